//--- rtl/input_ref_cfg.svh
`ifndef INPUT_REF_CFG_SVH
`define INPUT_REF_CFG_SVH

// Register offsets.
`define INPUT_ACTIVITY_STATUS_ADDR 8'h11
`define FIRST_INPUT_REF_CONFIG_ADDR 8'h22

// Field positions.
`define STAT_SECOND_ALARM_BIT 5
`define STAT_FIRST_ALARM_BIT 1
`define CFG_PREDIVIDER_BIT 7
`define CFG_LOCK8K_BIT 6
`define CFG_FREQ_MSB 3
`define CFG_FREQ_LSB 0

// Reset values.
`define INPUT_ACTIVITY_STATUS_RESET 8'h22
`define FIRST_INPUT_REF_CONFIG_UPPER_RESET 4'h0

`endif

//--- rtl/input_ref_pkg.sv
package input_ref_pkg;

  typedef struct packed {
    logic stat_second_q;
    logic stat_first_q;
    logic predivider_q;
    logic lock8k_q;
    logic [3:0] freq_q;
    logic pins_loaded_q;
    logic route_div_q;
    logic [7:0] rdata_q;
  } regs_s;

endpackage

//--- rtl/input_reference_status_config.sv
// Function
// - Status bit 5 mirrors second input alarm.
// - Status bit 1 mirrors first input alarm.
// - Status register writable only in test mode.
// - Status register resets to 0x22.
// - Config bit 7 selects pre-divider route.
// - Config upper nibble resets zero, lower from pins.
// - Expected frequency code in config bits 3:0.
// - Lock-at-8kHz forces pre-divider route.
`include "input_ref_cfg.svh"

module input_reference_status_config (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  // Monitors, pins and test mode.
  input wire logic no_activity_first,
  input wire logic no_activity_second,
  input wire logic test_mode,
  input wire logic [2:0] input_frequency_pins,
  input wire logic network_standard_pin,
  // Configuration towards the input path.
  output logic predivider_select,
  output logic lock_at_eight_khz,
  output logic [3:0] expected_input_frequency_code,
  output logic route_via_predivider
);

  input_ref_pkg::regs_s s_q;
  input_ref_pkg::regs_s s_d;

  // Reset words are kept at their full width so that single bits can be picked out
  // of them without any silent truncation.
  localparam logic [7:0] status_reset_value = `INPUT_ACTIVITY_STATUS_RESET;
  localparam logic [3:0] config_upper_reset = `FIRST_INPUT_REF_CONFIG_UPPER_RESET;

  function automatic logic [7:0] status_word(input logic second, input logic first);
    logic [7:0] w;
    w = 8'h00;
    w[`STAT_SECOND_ALARM_BIT] = second;
    w[`STAT_FIRST_ALARM_BIT] = first;
    return w;
  endfunction

  function automatic logic [7:0] config_word(input logic div, input logic l8k,
                                             input logic [3:0] freq);
    logic [7:0] w;
    w = 8'h00;
    w[`CFG_PREDIVIDER_BIT] = div;
    w[`CFG_LOCK8K_BIT] = l8k;
    w[`CFG_FREQ_MSB:`CFG_FREQ_LSB] = freq;
    return w;
  endfunction

  logic wr_status;
  logic wr_config;
  assign wr_status = reg_wr_en && (reg_addr == `INPUT_ACTIVITY_STATUS_ADDR);
  assign wr_config = reg_wr_en && (reg_addr == `FIRST_INPUT_REF_CONFIG_ADDR);

  always_comb
  begin
    s_d = s_q;
    // Alarms follow the monitors outside test mode; in test mode they hold unless a status write loads them.
    if (!test_mode)
    begin
      s_d.stat_second_q = no_activity_second;
      s_d.stat_first_q = no_activity_first;
    end
    else if (wr_status)
    begin
      s_d.stat_second_q = reg_wdata[`STAT_SECOND_ALARM_BIT];
      s_d.stat_first_q = reg_wdata[`STAT_FIRST_ALARM_BIT];
    end
    // Pins are sampled on the first edge after reset release, since an
    // asynchronous reset may only load constants.
    if (!s_q.pins_loaded_q)
    begin
      s_d.pins_loaded_q = 1'b1;
      s_d.freq_q = {network_standard_pin, input_frequency_pins};
    end
    else if (wr_config)
    begin
      s_d.predivider_q = reg_wdata[`CFG_PREDIVIDER_BIT];
      s_d.lock8k_q = reg_wdata[`CFG_LOCK8K_BIT];
      s_d.freq_q = reg_wdata[`CFG_FREQ_MSB:`CFG_FREQ_LSB];
    end
    s_d.route_div_q = s_d.predivider_q | s_d.lock8k_q;
    if (reg_rd_en)
    begin
      case (reg_addr)
        `INPUT_ACTIVITY_STATUS_ADDR:
          s_d.rdata_q = status_word(s_q.stat_second_q, s_q.stat_first_q);
        `FIRST_INPUT_REF_CONFIG_ADDR:
          s_d.rdata_q = config_word(s_q.predivider_q, s_q.lock8k_q, s_q.freq_q);
        default:
          s_d.rdata_q = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q.stat_second_q <= status_reset_value[`STAT_SECOND_ALARM_BIT];
      s_q.stat_first_q <= status_reset_value[`STAT_FIRST_ALARM_BIT];
      s_q.predivider_q <= config_upper_reset[3];
      s_q.lock8k_q <= config_upper_reset[2];
      s_q.freq_q <= 4'h0;
      s_q.pins_loaded_q <= 1'b0;
      s_q.route_div_q <= 1'b0;
      s_q.rdata_q <= 8'h00;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata_q;
  assign predivider_select = s_q.predivider_q;
  assign lock_at_eight_khz = s_q.lock8k_q;
  assign expected_input_frequency_code = s_q.freq_q;
  assign route_via_predivider = s_q.route_div_q;

  property p_second_alarm;
    @(posedge core_clk) disable iff (!rstn)
      !test_mode |=> (s_q.stat_second_q == $past(no_activity_second));
  endproperty
  a_second_alarm: assert property (p_second_alarm) else $error("second alarm bit wrong");

  // The read path is checked end to end: monitor level, status bit, then read data.
  property p_first_alarm;
    @(posedge core_clk) disable iff (!rstn)
      (!test_mode ##1 (reg_rd_en && reg_addr == `INPUT_ACTIVITY_STATUS_ADDR))
      |=> (reg_rdata[`STAT_FIRST_ALARM_BIT] == $past(no_activity_first, 2));
  endproperty
  a_first_alarm: assert property (p_first_alarm) else $error("first alarm read wrong");

  property p_alarm5_read;
    @(posedge core_clk) disable iff (!rstn)
      (!test_mode ##1 (reg_rd_en && reg_addr == `INPUT_ACTIVITY_STATUS_ADDR))
      |=> (reg_rdata[`STAT_SECOND_ALARM_BIT] == $past(no_activity_second, 2));
  endproperty
  a_alarm5_read: assert property (p_alarm5_read) else $error("bit 5 read wrong");

  property p_status_ro;
    @(posedge core_clk) disable iff (!rstn)
      (!test_mode && wr_status) |=>
        ({s_q.stat_second_q, s_q.stat_first_q}
         == {$past(no_activity_second), $past(no_activity_first)});
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status written outside test");

  property p_status_test_write;
    @(posedge core_clk) disable iff (!rstn)
      (test_mode && wr_status) |=>
        (s_q.stat_second_q == $past(reg_wdata[`STAT_SECOND_ALARM_BIT]))
        && (s_q.stat_first_q == $past(reg_wdata[`STAT_FIRST_ALARM_BIT]));
  endproperty
  a_status_test_write: assert property (p_status_test_write) else $error("test write lost");

  property p_status_hold_in_test;
    @(posedge core_clk) disable iff (!rstn)
      (test_mode && !wr_status) |=> $stable(s_q.stat_first_q) && $stable(s_q.stat_second_q);
  endproperty
  a_status_hold_in_test: assert property (p_status_hold_in_test) else $error("status moved");

  // The first edge of reset is skipped, since the registers may still be unknown
  // before the reset has been applied once.
  property p_status_reset;
    @(posedge core_clk)
      (!rstn ##1 !rstn) |-> (status_word(s_q.stat_second_q, s_q.stat_first_q)
                 == `INPUT_ACTIVITY_STATUS_RESET);
  endproperty
  a_status_reset: assert property (p_status_reset) else $error("status reset value wrong");

  property p_pin_load;
    @(posedge core_clk) disable iff (!rstn)
      !s_q.pins_loaded_q |=> s_q.pins_loaded_q && !predivider_select && !lock_at_eight_khz
        && (expected_input_frequency_code
            == {$past(network_standard_pin), $past(input_frequency_pins)});
  endproperty
  a_pin_load: assert property (p_pin_load) else $error("pin load wrong");

  property p_config_write;
    @(posedge core_clk) disable iff (!rstn)
      (s_q.pins_loaded_q && wr_config) |=>
        (config_word(predivider_select, lock_at_eight_khz, expected_input_frequency_code)
         == ($past(reg_wdata) & 8'hcf));
  endproperty
  a_config_write: assert property (p_config_write) else $error("config write wrong");

  property p_route;
    @(posedge core_clk) disable iff (!rstn)
      ##1 (route_via_predivider == (predivider_select | lock_at_eight_khz));
  endproperty
  a_route: assert property (p_route) else $error("route select wrong");

  property p_lock_route;
    @(posedge core_clk) disable iff (!rstn)
      lock_at_eight_khz |-> route_via_predivider;
  endproperty
  a_lock_route: assert property (p_lock_route) else $error("lock route missing");

  property p_unused_zero;
    @(posedge core_clk) disable iff (!rstn)
      (reg_rd_en && reg_addr == `INPUT_ACTIVITY_STATUS_ADDR) |=> ((reg_rdata & 8'hdd) == 8'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits nonzero");

  property p_cfg_unused_zero;
    @(posedge core_clk) disable iff (!rstn)
      (reg_rd_en && reg_addr == `FIRST_INPUT_REF_CONFIG_ADDR) |=> (reg_rdata[5:4] == 2'h0);
  endproperty
  a_cfg_unused_zero: assert property (p_cfg_unused_zero) else $error("bits 5:4 set");

  property p_unmapped_zero;
    @(posedge core_clk) disable iff (!rstn)
      (reg_rd_en && reg_addr != `INPUT_ACTIVITY_STATUS_ADDR
       && reg_addr != `FIRST_INPUT_REF_CONFIG_ADDR) |=> (reg_rdata == 8'h00);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read set");

endmodule // input_reference_status_config

//--- bench/ref_source_model.sv
module ref_source_model (
  // Source health, one bit per input.
  input wire logic [1:0] src_alive,
  // Activity monitor alarms.
  output logic no_activity_first,
  output logic no_activity_second
);
  timeunit 1ns;
  timeprecision 1ns;

  // A dead source shows as a steady alarm level; the clock edges themselves are not
  // modelled, which keeps the model small but hides monitor timing.
  assign no_activity_first = ~src_alive[0];
  assign no_activity_second = ~src_alive[1];
endmodule // ref_source_model

//--- bench/input_reference_status_config_tb.sv
module input_reference_status_config_tb;
  timeunit 1ns;
  timeprecision 1ns;

  `define CHK(g, e) \
    begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd_en = 1'b0;
  logic test_mode = 1'b0;
  logic [1:0] src_alive = 2'h0;
  logic [2:0] freq_pins = 3'h5;
  logic std_pin = 1'b1;
  logic [7:0] reg_rdata;
  logic na1, na2, pdiv, l8k, route;
  logic [3:0] code;
  int num_errors = 0;
  int cmp_count = 0;

  always #25 core_clk = ~core_clk;

  ref_source_model src (
    .src_alive(src_alive),
    .no_activity_first(na1),
    .no_activity_second(na2)
  );

  input_reference_status_config dut (
    .core_clk(core_clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata),
    .no_activity_first(na1),
    .no_activity_second(na2),
    .test_mode(test_mode),
    .input_frequency_pins(freq_pins),
    .network_standard_pin(std_pin),
    .predivider_select(pdiv),
    .lock_at_eight_khz(l8k),
    .expected_input_frequency_code(code),
    .route_via_predivider(route)
  );

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    @(posedge core_clk);
  endtask

  // Read data holds until the next read, so it is compared one edge late.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    @(posedge core_clk);
    `CHK(reg_rdata, e)
  endtask

  // Read on the edge after the write, before the monitors could hide a stray write.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    @(posedge core_clk);
    `CHK(reg_rdata, e)
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog so a stuck run still reaches the verdict.
  initial
  begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    end_sim();
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(8'h11, 8'h22);
    rd(8'h22, 8'h0d);
    `CHK(code, 4'hd)
    `CHK({pdiv, l8k, route}, 3'h0)
    src_alive <= 2'h1;
    rd(8'h11, 8'h20);
    src_alive <= 2'h2;
    rd(8'h11, 8'h02);
    src_alive <= 2'h3;
    wr_rd(8'h11, 8'hff, 8'h00);
    test_mode <= 1'b1;
    wr(8'h11, 8'hff);
    rd(8'h11, 8'h22);
    wr(8'h22, 8'hff);
    rd(8'h22, 8'hcf);
    wr(8'h22, 8'h40);
    `CHK({pdiv, l8k, route}, 3'h3)
    wr(8'h22, 8'h85);
    `CHK({pdiv, l8k, route, code}, 7'h55)
    freq_pins <= 3'h2;
    std_pin <= 1'b0;
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK({pdiv, l8k, route}, 3'h0)
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(8'h11, 8'h22);
    rd(8'h22, 8'h02);
    rd(8'h33, 8'h00);
    end_sim();
  end
endmodule // input_reference_status_config_tb
